/* File: design/monitor_pkg.sv */
// Constants shared by the drive monitor register bank
package monitor_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DATA_W        = 16;
   localparam int ADDR_W        = 16;
   localparam int NUM_TERMINALS = 12;
   localparam int NUM_OUTPUTS   = 5;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [15:0] BANK_LO       = 16'h0029;
   localparam logic [15:0] BANK_HI       = 16'h003F;
   localparam logic [15:0] SEQ_IN_ADDR   = 16'h002B;
   localparam logic [15:0] STATE_ADDR    = 16'h002C;
   localparam logic [15:0] OUT_LVL_ADDR  = 16'h002D;
   localparam logic [15:0] DC_BUS_ADDR   = 16'h0031;
   localparam logic [15:0] TORQUE_ADDR   = 16'h0032;
   localparam logic [15:0] POWER_ADDR    = 16'h0033;
   localparam logic [15:0] LOOP_FB_ADDR  = 16'h0038;
   localparam logic [15:0] LOOP_IN_ADDR  = 16'h0039;
   localparam logic [15:0] LOOP_OUT_ADDR = 16'h003A;
   localparam logic [15:0] FW_MAIN_ADDR  = 16'h003B;
   localparam logic [15:0] FW_STORE_ADDR = 16'h003C;
   localparam logic [15:0] LINK_ERR_ADDR = 16'h003D;
   localparam logic [15:0] RATING_ADDR   = 16'h003E;
   localparam logic [15:0] METHOD_ADDR   = 16'h003F;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ERR_CRC_BIT     = 0;
   localparam int ERR_LENGTH_BIT  = 1;
   localparam int ERR_PARITY_BIT  = 3;
   localparam int ERR_OVERRUN_BIT = 4;
   localparam int ERR_FRAMING_BIT = 5;
   localparam int ERR_TIMEOUT_BIT = 6;
   localparam logic [15:0] ERR_USED_MASK = 16'h007B;

   // ****************************************
   // Reset values and answer codes
   // ****************************************
   localparam logic [15:0] WORD_RESET   = 16'h0000;
   localparam logic [7:0]  EXC_NONE     = 8'h00;
   localparam logic [7:0]  EXC_BAD_REG  = 8'h02;
   localparam logic [7:0]  EXC_WRITE_RO = 8'h22;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ANSWER = 2'b01
   } answer_state_t;

endpackage

/* File: design/err_latch_if.sv */
// Signals between the register bank and its link error latch
`timescale 1ns/1ps
interface err_latch_if;
   logic [15:0] events;
   logic        clear;
   logic [15:0] latched;

   modport owner (input events, input clear, output latched);
   modport user  (output events, output clear, input latched);
endinterface // err_latch_if

/* File: design/link_error_latch_unit.sv */
// Sticky latch for link error flags, cleared by a fault reset
`timescale 1ns/1ps
module link_error_latch_unit
   import monitor_pkg::*;
(
   // Clock and reset
   input wire logic     clk,
   input wire logic     rst_b,
   // Flags
   err_latch_if.owner   err
);

   logic [15:0] flag_q;
   logic [15:0] flag_d;

   // ****************************************
   // Per-bit latch
   // ****************************************
   for (genvar i = 0; i < DATA_W; i++) begin : g_flag
      if (ERR_USED_MASK[i]) begin : g_used
         // An event in the clearing cycle is kept [R13] [R14]
         assign flag_d[i] = err.events[i] | (flag_q[i] & ~err.clear);
      end else begin : g_unused
         assign flag_d[i] = 1'b0; // [R17]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= WORD_RESET;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign err.latched = flag_q;

endmodule // link_error_latch_unit

/* File: design/drive_monitor_status_registers.sv */
// Read-only monitor register bank of the drive, served to the link master
`timescale 1ns/1ps

// Function
// (R1) Terminals one to twelve show on sequence input bits 0 to B, 1 meaning on, bits C to F zero.
// (R2) Status bits 0 to 3 show running, zero speed, frequency matched and user speed matched.
// (R3) Status bits 4 to 7 show frequency detection 1 and 2, startup completed and low voltage.
// (R4) Status bit 8 is 1 while the output stage is in baseblock.
// (R5) Status bit 9 is 0 when the frequency reference comes from the link, else 1.
// (R6) Status bit A is 0 when run commands come from the link, else 1.
// (R7) Status bits B, C and D show overtorque, reference lost and error retry.
// (R8) Status bit F shows a link time-out and bit E any error, a time-out included.
// (R9) Output word bits 0 to 4 show three contact and two photocoupler outputs, bits 5 to F zero.
// (R10) DC bus voltage, torque and output power sit as read-only words at consecutive addresses.
// (R11) Loop feedback is unsigned at ten counts per percent of maximum output frequency.
// (R12) Loop output is signed at ten counts per percent, spanning plus and minus maximum.
// (R13) Link error flags for CRC, length, parity, overrun, framing and time-out latch until fault reset.
// (R14) The fault reset that clears the link error flags is taken even while running.
// (R15) Every monitor register is read-only.
// (R16) A write aimed at read-only data is answered with exception 22H.
// (R17) Unused bits and unused registers read as zero.
module drive_monitor_status_registers
   import monitor_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,

   // Register request from the frame handler
   input  wire logic                     req_valid,
   input  wire logic                     req_write,
   input  wire logic [ADDR_W-1:0]        req_addr,
   input  wire logic [DATA_W-1:0]        req_wdata,
   output      logic                     req_ready,

   // Register answer to the frame handler
   output      logic                     rsp_valid,
   output      logic [DATA_W-1:0]        rsp_rdata,
   output      logic [7:0]               rsp_exception,

   // Input terminal pins
   // Asynchronous, synchronised below
   input  wire logic [NUM_TERMINALS-1:0] terminal_pins,

   // Drive state from the control core
   // Same-clock levels
   input  wire logic                     running,
   input  wire logic                     zero_speed,
   input  wire logic                     freq_matched,
   input  wire logic                     user_speed_matched,
   input  wire logic                     freq_detect_one,
   input  wire logic                     freq_detect_two,
   input  wire logic                     startup_done,
   input  wire logic                     low_voltage,
   input  wire logic                     output_baseblock,
   input  wire logic                     freq_ref_from_link,
   input  wire logic                     run_cmd_from_link,
   input  wire logic                     overtorque,
   input  wire logic                     freq_ref_lost,
   input  wire logic                     error_retrying,
   input  wire logic                     fault_active,
   input  wire logic                     link_timed_out,

   // Multi-function output levels
   input  wire logic [2:0]               relay_output_levels,
   input  wire logic                     photocoupler_output_three_pair,
   input  wire logic                     photocoupler_output_four_pair,

   // Monitor values
   // Loop output is two's complement
   input  wire logic [DATA_W-1:0]        dc_bus_value,
   input  wire logic [DATA_W-1:0]        torque_value,
   input  wire logic [DATA_W-1:0]        power_monitor_item,
   input  wire logic [DATA_W-1:0]        process_loop_feedback,
   input  wire logic [DATA_W-1:0]        process_loop_input,
   input  wire logic signed [DATA_W-1:0] process_loop_output,
   input  wire logic [DATA_W-1:0]        main_fw_value,
   input  wire logic [DATA_W-1:0]        stored_fw_value,
   input  wire logic [DATA_W-1:0]        rating_value,
   input  wire logic [DATA_W-1:0]        method_value,

   // Link error events and fault reset
   // Events are same-clock pulses
   input  wire logic                     crc_error_seen,
   input  wire logic                     length_error_seen,
   input  wire logic                     parity_error_seen,
   input  wire logic                     overrun_error_seen,
   input  wire logic                     framing_error_seen,
   input  wire logic                     timeout_seen,
   input  wire logic                     fault_reset
);

   // ****************************************
   // Decode helpers
   // ****************************************


   // True for any word of the monitor bank, used or not
   // Outside it a request is a bad register
   function automatic logic in_bank(input logic [ADDR_W-1:0] a);
      in_bank = (a >= BANK_LO) && (a <= BANK_HI);
   endfunction


   // True for a word that carries data; the rest read zero
   // Holes in the map exist but carry nothing
   function automatic logic is_live(input logic [ADDR_W-1:0] a);
      unique case (a)
         SEQ_IN_ADDR, STATE_ADDR, OUT_LVL_ADDR,
         DC_BUS_ADDR, TORQUE_ADDR, POWER_ADDR,
         LOOP_FB_ADDR, LOOP_IN_ADDR, LOOP_OUT_ADDR,
         FW_MAIN_ADDR, FW_STORE_ADDR, LINK_ERR_ADDR,
         RATING_ADDR, METHOD_ADDR: is_live = 1'b1;
         default:                  is_live = 1'b0;
      endcase
   endfunction

   // ****************************************
   // Terminal synchroniser
   // ****************************************


   // Pins are asynchronous; only the second stage is read
   // Two stages cost two cycles of delay
   // A pulse shorter than a clock may be missed
   logic [NUM_TERMINALS-1:0] term_meta_q;
   logic [NUM_TERMINALS-1:0] term_sync_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         term_meta_q <= '0;
         term_sync_q <= '0;
      end else begin
         // First stage may go metastable
         term_meta_q <= terminal_pins;
         term_sync_q <= term_meta_q;
      end
   end

   // ****************************************
   // Word assembly
   // ****************************************

   // Assembled words, all combinational
   wire logic [DATA_W-1:0] seq_in_word;
   wire logic [DATA_W-1:0] state_word;
   wire logic [DATA_W-1:0] out_lvl_word;
   wire logic [DATA_W-1:0] loop_out_word;
   wire logic              any_error;


   // Terminal one on bit 0
   // Bits C to F stay zero
   assign seq_in_word = {4'h0, term_sync_q}; // [R1] [R17]


   // A time-out counts as an error as well
   assign any_error = fault_active | link_timed_out; // [R8]


   // Motion and speed state
   assign state_word[0]  = running;            // [R2]
   assign state_word[1]  = zero_speed;         // [R2]
   assign state_word[2]  = freq_matched;       // [R2]
   assign state_word[3]  = user_speed_matched; // [R2]

   // Detection and supply state
   assign state_word[4]  = freq_detect_one;    // [R3]
   assign state_word[5]  = freq_detect_two;    // [R3]
   assign state_word[6]  = startup_done;       // [R3]
   assign state_word[7]  = low_voltage;        // [R3]

   // Output stage switched off
   assign state_word[8]  = output_baseblock;   // [R4]
   // Source bits are inverted: 0 means the link is in charge
   assign state_word[9]  = ~freq_ref_from_link; // [R5]
   assign state_word[10] = ~run_cmd_from_link;  // [R6]

   // Fault side of the word
   assign state_word[11] = overtorque;          // [R7]
   assign state_word[12] = freq_ref_lost;       // [R7]
   assign state_word[13] = error_retrying;      // [R7]
   assign state_word[14] = any_error;           // [R8]
   assign state_word[15] = link_timed_out;      // [R8]

   // Relays on bits 0 to 2, photocouplers on 3 and 4
   assign out_lvl_word = {11'h000,
                          photocoupler_output_four_pair,
                          photocoupler_output_three_pair,
                          relay_output_levels}; // [R9] [R17]

   // Two's complement, ten counts per percent, carried unchanged
   // Scaling is done by the control core
   assign loop_out_word = process_loop_output; // [R12]


   // ****************************************
   // Link error latch
   // ****************************************

   // Kept apart so the set-wins rule lives in one place
   err_latch_if err_bus ();

   // Event pulses packed in register order
   wire logic [DATA_W-1:0] err_events;

   // Bit 2 has no event and stays zero
   assign err_events = {9'h000,
                        timeout_seen,
                        framing_error_seen,
                        overrun_error_seen,
                        parity_error_seen,
                        1'b0,
                        length_error_seen,
                        crc_error_seen}; // [R13]


   assign err_bus.events = err_events;
   // Taken whatever the run state is
   assign err_bus.clear  = fault_reset; // [R14]


   link_error_latch_unit u_err_latch (
      .clk   (clk),
      .rst_b (rst_b),
      .err   (err_bus)
   );

   // ****************************************
   // Read selection
   // ****************************************

   logic [DATA_W-1:0] read_word;

   // Unlisted addresses fall to zero

   always_comb begin
      read_word = WORD_RESET;
      unique case (req_addr)
         SEQ_IN_ADDR:   read_word = seq_in_word;            // [R1]
         STATE_ADDR:    read_word = state_word;             // [R2]
         OUT_LVL_ADDR:  read_word = out_lvl_word;           // [R9]
         DC_BUS_ADDR:   read_word = dc_bus_value;           // [R10]
         TORQUE_ADDR:   read_word = torque_value;           // [R10]
         POWER_ADDR:    read_word = power_monitor_item;     // [R10]
         LOOP_FB_ADDR:  read_word = process_loop_feedback;  // [R11]
         LOOP_IN_ADDR:  read_word = process_loop_input;
         LOOP_OUT_ADDR: read_word = loop_out_word;          // [R12]
         FW_MAIN_ADDR:  read_word = main_fw_value;
         FW_STORE_ADDR: read_word = stored_fw_value;
         LINK_ERR_ADDR: read_word = err_bus.latched;        // [R13]
         RATING_ADDR:   read_word = rating_value;
         METHOD_ADDR:   read_word = method_value;
         default:       read_word = WORD_RESET;             // [R17]
      endcase
   end

   // ****************************************
   // Request decode
   // ****************************************

   // Request side wires
   wire logic              req_take;
   wire logic              addr_in_bank;
   wire logic              addr_live;
   wire logic [7:0]        exc_code;
   wire logic [DATA_W-1:0] answer_word;


   // Both decodes look at the held address
   assign addr_in_bank = in_bank(req_addr);
   assign addr_live    = is_live(req_addr);


   // Bad address wins over write
   // Writes never store: the bank has no writable bit
   assign exc_code = !addr_in_bank ? EXC_BAD_REG :
                     req_write     ? EXC_WRITE_RO : // [R15] [R16]
                                     EXC_NONE;


   // Unused words of the bank answer zero, not an error
   assign answer_word = (addr_live && !req_write) ? read_word
                                                  : WORD_RESET; // [R17]

   // ****************************************
   // Answer sequencer
   // ****************************************

   // Sequencer state and answer registers
   answer_state_t     state_q;
   answer_state_t     state_d;
   logic [DATA_W-1:0] rdata_q;
   logic [7:0]        exc_q;


   // One answer in flight; req_ready drops for the answer cycle
   // so two requests are never taken back to back
   assign req_take  = req_valid && (state_q == ST_IDLE);
   assign req_ready = (state_q == ST_IDLE);


   // The answer state always lasts one cycle
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:   if (req_valid) state_d = ST_ANSWER;
         ST_ANSWER: state_d = ST_IDLE;
         default:   state_d = ST_IDLE;
      endcase
   end


   // Reset leaves the bank idle and ready
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end


   // Values are sampled on the accepting edge, so a word is coherent
   // A write leaves zero data behind
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= WORD_RESET;
         exc_q   <= EXC_NONE;
      end else if (req_take) begin
         rdata_q <= answer_word;
         exc_q   <= exc_code; // [R16]
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   // Strobes decode the state; data comes from flops
   assign rsp_valid     = (state_q == ST_ANSWER);
   assign rsp_rdata     = rdata_q;
   assign rsp_exception = exc_q;


endmodule // drive_monitor_status_registers

/* File: sim/status_bank_monitor.sv */
// Concurrent checks on the ports of the drive monitor register bank
`timescale 1ns/1ps
module status_bank_checker
   import monitor_pkg::*;
(
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst_b,
   // Request and answer
   input wire logic               req_valid,
   input wire logic               req_write,
   input wire logic [15:0]        req_addr,
   input wire logic               req_ready,
   input wire logic               rsp_valid,
   input wire logic [15:0]        rsp_rdata,
   input wire logic [7:0]         rsp_exception,
   // Watched sources
   input wire logic [11:0]        terminal_pins,
   input wire logic [2:0]         relay_output_levels,
   input wire logic               photocoupler_output_three_pair,
   input wire logic               photocoupler_output_four_pair,
   input wire logic [15:0]        dc_bus_value,
   input wire logic signed [15:0] process_loop_output,
   input wire logic               crc_error_seen,
   input wire logic               fault_reset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   wire take    = req_valid && req_ready;
   wire in_bank = req_addr >= BANK_LO && req_addr <= BANK_HI;

   // ****************************************
   // Request shapes
   // ****************************************
   sequence rd_take(logic [15:0] a);
      take && !req_write && req_addr == a;
   endsequence
   sequence rd_unused;
      take && !req_write && req_addr inside {16'h0029, 16'h002A, [16'h002E:16'h0030], [16'h0034:16'h0037]};
   endsequence
   // Flag seen at one edge must show in a read taken at the next
   sequence crc_then_read;
      crc_error_seen ##1 rd_take(16'h003D);
   endsequence
   sequence clear_then_read;
      fault_reset && !crc_error_seen ##1 rd_take(16'h003D);
   endsequence

   // ****************************************
   // Checks
   // ****************************************
   answer_pulse_a: assert property (take |=> rsp_valid && !req_ready ##1 !rsp_valid)
      else $error("answer strobe not one cycle");
   write_refused_a: assert property (take && req_write && in_bank |=> rsp_exception == 8'h22 && rsp_rdata == 16'h0000)
      else $error("write not refused");
   outside_refused_a: assert property (take && !in_bank |=> rsp_exception == 8'h02 && rsp_rdata == 16'h0000)
      else $error("outside address not refused");
   input_levels_a: assert property ($stable(terminal_pins)[*3] ##0 rd_take(16'h002B) |=> rsp_rdata == {4'h0, $past(terminal_pins)})
      else $error("terminal word wrong");
   output_levels_a: assert property (rd_take(16'h002D) |=> rsp_rdata == {11'h000, $past(photocoupler_output_four_pair),
      $past(photocoupler_output_three_pair), $past(relay_output_levels)})
      else $error("output word wrong");
   dc_bus_word_a: assert property (rd_take(16'h0031) |=> rsp_rdata == $past(dc_bus_value) && rsp_exception == 8'h00)
      else $error("dc bus word wrong");
   loop_output_a: assert property (rd_take(16'h003A) |=> rsp_rdata == $past(process_loop_output))
      else $error("loop output word wrong");
   unused_zero_a: assert property (rd_unused |=> rsp_rdata == 16'h0000 && rsp_exception == 8'h00)
      else $error("unused word not zero");
   error_set_a: assert property (crc_then_read |=> rsp_rdata[0])
      else $error("crc flag not latched");
   error_clear_a: assert property (clear_then_read |=> !rsp_rdata[0])
      else $error("crc flag not cleared");
   error_unused_a: assert property (rd_take(16'h003D) |=> (rsp_rdata & 16'hFF84) == 16'h0000)
      else $error("unused error bits set");
endmodule // status_bank_checker

/* File: sim/master_model.sv */
// Link master stand-in issuing one register request at a time
`timescale 1ns/1ps
module master_model (
   // Clock
   input  wire logic        clk,
   // Request
   output      logic        req_valid,
   output      logic        req_write,
   output      logic [15:0] req_addr,
   output      logic [15:0] req_wdata,
   input  wire logic        req_ready,
   // Answer
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_rdata,
   input  wire logic [7:0]  rsp_exception
);
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr  = 16'h0000;
      req_wdata = 16'h0000;
   end

   // Enter and leave just after a rising edge
   task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] rd, output logic [7:0] ex, output logic ok);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_write = w;
      req_addr  = a;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      #1;
      // Released lines must not keep looking valid
      req_valid = 1'b0;
      req_write = ~w;
      req_addr  = ~a;
      req_wdata = ~d;
      ok = rsp_valid === 1'b1;
      rd = rsp_rdata;
      ex = rsp_exception;
      @(posedge clk);
      #1;
   endtask
endmodule // master_model

/* File: sim/test_drive_monitor_status_registers.sv */
// Self-checking bench for the drive monitor register bank
`timescale 1ns/1ps
module test_drive_monitor_status_registers
   import monitor_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b, req_valid, req_write, req_ready, rsp_valid, fault_reset;
   logic [15:0] req_addr, req_wdata, rsp_rdata, st, err_exp;
   logic [7:0] rsp_exception;
   logic [11:0] terminal_pins;
   logic [5:0] ev;
   logic [2:0] relay_output_levels;
   logic photocoupler_output_three_pair, photocoupler_output_four_pair;
   logic [15:0] dc_bus_value, torque_value, power_monitor_item, process_loop_feedback, process_loop_input;
   logic signed [15:0] process_loop_output;
   logic [15:0] main_fw_value, stored_fw_value, rating_value, method_value;
   wire running, zero_speed, freq_matched, user_speed_matched, freq_detect_one, freq_detect_two, startup_done;
   wire low_voltage, output_baseblock, freq_ref_from_link, run_cmd_from_link, overtorque, freq_ref_lost;
   wire error_retrying, fault_active, link_timed_out;
   wire crc_error_seen, length_error_seen, parity_error_seen, overrun_error_seen, framing_error_seen, timeout_seen;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   assign {link_timed_out, fault_active, error_retrying, freq_ref_lost, overtorque, run_cmd_from_link,
           freq_ref_from_link, output_baseblock, low_voltage, startup_done, freq_detect_two, freq_detect_one,
           user_speed_matched, freq_matched, zero_speed, running} = st;
   assign {timeout_seen, framing_error_seen, overrun_error_seen, parity_error_seen, length_error_seen,
           crc_error_seen} = ev;

   master_model m (.clk(clk), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_exception(rsp_exception));
   drive_monitor_status_registers dut (.*);

   always #50 clk = ~clk;

   // ****************************************
   // Expectations
   // ****************************************
   function automatic logic [15:0] exp_reg(input logic [15:0] a);
      case (a)
         SEQ_IN_ADDR:   exp_reg = {4'h0, terminal_pins};
         // Source bits read inverted: 0 means the link is the source
         STATE_ADDR:    exp_reg = {st[15], st[14] | st[15], st[13:11], ~st[10:9], st[8:0]};
         OUT_LVL_ADDR:  exp_reg = {11'h000, photocoupler_output_four_pair, photocoupler_output_three_pair,
                                   relay_output_levels};
         DC_BUS_ADDR:   exp_reg = dc_bus_value;
         TORQUE_ADDR:   exp_reg = torque_value;
         POWER_ADDR:    exp_reg = power_monitor_item;
         LOOP_FB_ADDR:  exp_reg = process_loop_feedback;
         LOOP_IN_ADDR:  exp_reg = process_loop_input;
         LOOP_OUT_ADDR: exp_reg = process_loop_output;
         FW_MAIN_ADDR:  exp_reg = main_fw_value;
         FW_STORE_ADDR: exp_reg = stored_fw_value;
         LINK_ERR_ADDR: exp_reg = err_exp;
         RATING_ADDR:   exp_reg = rating_value;
         METHOD_ADDR:   exp_reg = method_value;
         default:       exp_reg = 16'h0000;
      endcase
   endfunction

   function automatic logic [7:0] exp_code(input logic w, input logic [15:0] a);
      if (a < 16'h0029 || a > 16'h003F) exp_code = 8'h02;
      else exp_code = w ? 8'h22 : 8'h00;
   endfunction

   // ****************************************
   // Compare tasks
   // ****************************************
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_code(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic access_chk(input logic w, input logic [15:0] a);
      logic [15:0] rd;
      logic [7:0] ex;
      logic ok;
      m.access(w, a, 16'($urandom), rd, ex, ok);
      check_code($sformatf("strobe %h", a), 8'h01, {7'h00, ok});
      check_word($sformatf("data %h", a), w ? 16'h0000 : exp_reg(a), rd);
      check_code($sformatf("code %h", a), exp_code(w, a), ex);
   endtask

   task automatic fill(input logic [15:0] s, input logic [176:0] r);
      st = s;
      {dc_bus_value, torque_value, power_monitor_item, process_loop_feedback, process_loop_input,
       process_loop_output, main_fw_value, stored_fw_value, rating_value, method_value, terminal_pins,
       relay_output_levels, photocoupler_output_three_pair, photocoupler_output_four_pair} = r;
   endtask

   task automatic report_and_stop;
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_b = 1'b0;
      ev = 6'h00;
      fault_reset = 1'b0;
      err_exp = 16'h0000;
      fill(16'h0000, '0);
      void'($urandom(32'h4566));
      repeat (2) @(posedge clk);
      #1;
      rst_b = 1'b1;
      for (int i = 0; i < 12; i++) begin
         fill(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : i == 2 ? 16'h8000 : 16'($urandom),
              177'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom}));
         for (int a = 16'h0028; a <= 16'h0040; a++) access_chk(1'b1, 16'(a));
         access_chk(1'b0, 16'($urandom));
         for (int a = 16'h0028; a <= 16'h0040; a++) access_chk(1'b0, 16'(a));
      end
      // Link error flags raised one by one while running, then cleared
      st = 16'h0001;
      for (int k = 0; k < 6; k++) begin
         ev = 6'(1 << k);
         @(posedge clk);
         #1;
         ev = 6'h00;
         err_exp[k < 2 ? k : k + 1] = 1'b1;
         access_chk(1'b0, LINK_ERR_ADDR);
      end
      // An event on the clearing edge survives it
      ev = 6'h01;
      fault_reset = 1'b1;
      @(posedge clk);
      #1;
      ev = 6'h00;
      fault_reset = 1'b0;
      err_exp = 16'h0001;
      access_chk(1'b0, LINK_ERR_ADDR);
      fault_reset = 1'b1;
      @(posedge clk);
      #1;
      fault_reset = 1'b0;
      err_exp = 16'h0000;
      access_chk(1'b0, LINK_ERR_ADDR);
      report_and_stop();
   end
endmodule // test_drive_monitor_status_registers

bind drive_monitor_status_registers status_bank_checker chk (.*);
